// ==== hdl/qfs_params.svh ====
// Purpose: Constants for the quad FIFO status aggregator.
// Assumes: Four FIFOs of sixteen entries with one wrap bit per pointer.
// Notes:   Offsets are byte addresses; field positions are bit indices into the status word.
`ifndef QFS_PARAMS_SVH
`define QFS_PARAMS_SVH

// Geometry of each FIFO.
`define QFS_NUM_FIFO      4
`define QFS_PTR_W         5
`define QFS_DEPTH         5'h10
`define QFS_THR_W         3
`define QFS_ADDR_W        16

// Register map.
`define QFS_STATUS_OFFSET 16'h0004
`define QFS_STATUS_RESET  32'h0000_0000

// Field positions inside the status register.
`define QFS_FULL_LSB      0
`define QFS_EMPTY_LSB     4
`define QFS_AFULL_LSB     8
`define QFS_AEMPTY_LSB    12
`define QFS_ALL_FULL_BIT  16
`define QFS_ANY_EMPTY_BIT 17
`define QFS_ALL_AFULL_BIT 18
`define QFS_ANY_AEMPT_BIT 19
`define QFS_WMATCH_BIT    20
`define QFS_RMATCH_BIT    21
`define QFS_USED_W        22

`endif

// ==== hdl/qfs_pkg.sv ====
// Purpose: Types and shared arithmetic of the quad FIFO status aggregator.
// Assumes: The constants header is on the include path.
// Notes:   Pointer arithmetic wraps modulo two times the depth.
`include "qfs_params.svh"

package qfs_pkg;

    typedef logic [`QFS_PTR_W-1:0]    qfs_ptr_t;
    typedef qfs_ptr_t [`QFS_NUM_FIFO-1:0] qfs_ptr_vec_t;
    typedef logic [`QFS_NUM_FIFO-1:0] qfs_mask_t;
    typedef logic [`QFS_THR_W-1:0]    qfs_thr_t;
    typedef logic [`QFS_ADDR_W-1:0]   qfs_addr_t;

    // Fill level is the write pointer minus the read pointer, wrapping.
    function automatic qfs_ptr_t qfs_level(input qfs_ptr_t wp, input qfs_ptr_t rp);
        qfs_ptr_t diff;
        diff = wp - rp;
        return diff;
    endfunction

endpackage

// ==== hdl/qfs_fifo_flags.sv ====
// Purpose: Per-FIFO full, empty, almost-full and almost-empty conditions.
// Assumes: Pointers are synchronous to the status clock.
// Notes:   Purely combinational; the caller registers the results.
`timescale 1ns/10ps
`include "qfs_params.svh"

module qfs_fifo_flags (
    // Control.
    input  wire logic              enable,
    input  wire qfs_pkg::qfs_thr_t full_thresh,
    input  wire qfs_pkg::qfs_thr_t empty_thresh,
    // Pointers.
    input  wire qfs_pkg::qfs_ptr_t wr_ptr,
    input  wire qfs_pkg::qfs_ptr_t rd_ptr,
    // Conditions.
    output logic                   full,
    output logic                   empty,
    output logic                   almost_full,
    output logic                   almost_empty
);
    import qfs_pkg::*;

    qfs_ptr_t level;

    // A disabled FIFO reports nothing, whatever its pointers hold.
    always_comb begin
        level        = qfs_level(wr_ptr, rd_ptr);
        full         = enable && (level == `QFS_DEPTH);
        empty        = enable && (level == '0);
        almost_full  = enable && (level > {2'b00, full_thresh});
        almost_empty = enable && (level < {2'b00, empty_thresh});
    end

endmodule

// ==== hdl/qfs_ptr_match.sv ====
// Purpose: Tells whether the pointers of all enabled FIFOs hold one value.
// Assumes: Four pointers of equal width.
// Notes:   With no FIFO enabled the match reads zero.
`timescale 1ns/10ps
`include "qfs_params.svh"

module qfs_ptr_match (
    // Selection.
    input  wire qfs_pkg::qfs_mask_t    enable,
    // Pointers.
    input  wire qfs_pkg::qfs_ptr_vec_t ptr,
    // Result.
    output logic                       match
);
    import qfs_pkg::*;

    qfs_ptr_t ref_ptr;
    logic     found;
    logic     same;

    // The lowest enabled pointer is the reference; any other enabled one must equal it.
    always_comb begin
        ref_ptr = '0;
        found   = 1'b0;
        same    = 1'b1;
        for (int i = 0; i < `QFS_NUM_FIFO; i++) begin
            if (enable[i] && !found) begin
                ref_ptr = ptr[i];
                found   = 1'b1;
            end else if (enable[i] && (ptr[i] != ref_ptr)) begin
                same = 1'b0;
            end
        end
        match = found && same;
    end

endmodule

// ==== hdl/qfs_status.sv ====
// Purpose: Status register of a bank of four accelerator input FIFOs.
// Assumes: Pointers, enables and thresholds are synchronous to clock.
// Notes:   Flags are registered once; reads return the registered word.
//          Flags follow their condition every cycle with ce high and hold with ce low; none of them is sticky.
//
// Functional notes
// - Read-match bit high exactly when at least one FIFO is enabled and all enabled FIFO read pointers are equal.
// - Write-match bit high exactly when at least one FIFO is enabled and all enabled FIFO write pointers are equal.
// - Aggregate almost-empty is the OR of the four per-FIFO bits.
// - Aggregate almost-full is the AND of the four per-FIFO bits.
// - Aggregate empty is the OR of the four per-FIFO empty bits.
// - Aggregate full is the AND of the four per-FIFO full bits.
// - Bits 15:12 show per-FIFO almost empty, bit 0 is FIFO 0.
// - Bits 11:8 show per-FIFO almost full, bit 0 is FIFO 0.
// - Bits 7:4 show per-FIFO empty, bit 0 is FIFO 0.
// - Bits 3:0 show per-FIFO full, bit 0 is FIFO 0.
// - Each per-FIFO bit follows its condition; a disabled FIFO reads all zero.
// - Almost full when pointer difference exceeds the three-bit full threshold.
// - Almost empty when pointer difference is below the three-bit empty threshold.
`timescale 1ns/10ps
`include "qfs_params.svh"

module qfs_status (
    // Clock, reset and enable.
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // FIFO control.
    input  wire qfs_pkg::qfs_mask_t    fifo_enable,
    input  wire qfs_pkg::qfs_thr_t     full_thresh,
    input  wire qfs_pkg::qfs_thr_t     empty_thresh,
    // FIFO pointers.
    input  wire qfs_pkg::qfs_ptr_vec_t wr_ptr,
    input  wire qfs_pkg::qfs_ptr_vec_t rd_ptr,
    // Register read port.
    input  wire logic                  rd_en,
    input  wire qfs_pkg::qfs_addr_t    rd_addr,
    output logic [31:0]                rd_data,
    output logic                       rd_valid,
    // Live status word.
    output logic [31:0]                fifo_status
);
    import qfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Per-FIFO conditions.

    qfs_mask_t full_c;
    qfs_mask_t empty_c;
    qfs_mask_t afull_c;
    qfs_mask_t aempty_c;
    logic      rd_match_c;
    logic      wr_match_c;

    // One flag slice per FIFO; bit n of every field belongs to FIFO n.
    for (genvar g = 0; g < `QFS_NUM_FIFO; g++) begin : g_fifo
        qfs_fifo_flags u_flags (
            .enable       (fifo_enable[g]),
            .full_thresh  (full_thresh),
            .empty_thresh (empty_thresh),
            .wr_ptr       (wr_ptr[g]),
            .rd_ptr       (rd_ptr[g]),
            .full         (full_c[g]),
            .empty        (empty_c[g]),
            .almost_full  (afull_c[g]),
            .almost_empty (aempty_c[g])
        );
    end

    // Only enabled FIFOs take part in the pointer comparisons.
    qfs_ptr_match u_rd_match (
        .enable (fifo_enable),
        .ptr    (rd_ptr),
        .match  (rd_match_c)
    );

    qfs_ptr_match u_wr_match (
        .enable (fifo_enable),
        .ptr    (wr_ptr),
        .match  (wr_match_c)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status word.

    logic [31:0] next_fifo_status;

    // Assemble the word; aggregates use the gated bits so disabled FIFOs count as clear.
    always_comb begin
        next_fifo_status = `QFS_STATUS_RESET;
        next_fifo_status[`QFS_FULL_LSB   +: `QFS_NUM_FIFO] = full_c;
        next_fifo_status[`QFS_EMPTY_LSB  +: `QFS_NUM_FIFO] = empty_c;
        next_fifo_status[`QFS_AFULL_LSB  +: `QFS_NUM_FIFO] = afull_c;
        next_fifo_status[`QFS_AEMPTY_LSB +: `QFS_NUM_FIFO] = aempty_c;
        next_fifo_status[`QFS_ALL_FULL_BIT]  = &full_c;
        next_fifo_status[`QFS_ANY_EMPTY_BIT] = |empty_c;
        next_fifo_status[`QFS_ALL_AFULL_BIT] = &afull_c;
        next_fifo_status[`QFS_ANY_AEMPT_BIT] = |aempty_c;
        next_fifo_status[`QFS_WMATCH_BIT]    = wr_match_c;
        next_fifo_status[`QFS_RMATCH_BIT]    = rd_match_c;
        if (!ce) begin
            next_fifo_status = fifo_status;
        end
    end

    // The flags are registered so that a read never sees a half-settled compare.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fifo_status <= `QFS_STATUS_RESET;
        end else begin
            fifo_status <= next_fifo_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port.

    logic [31:0] next_rd_data;
    logic        next_rd_valid;

    // Reads return the registered word; other addresses return zero.
    always_comb begin
        next_rd_data  = rd_data;
        next_rd_valid = rd_valid;
        if (ce) begin
            next_rd_valid = rd_en;
            if (rd_en && (rd_addr == `QFS_STATUS_OFFSET)) begin
                next_rd_data = fifo_status;
            end else if (rd_en) begin
                next_rd_data = 32'h0000_0000;
            end
        end
    end

    // There is no write path at all, so software cannot disturb the flags.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data  <= 32'h0000_0000;
            rd_valid <= 1'b0;
        end else begin
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Helper levels for FIFOs 0 to 3, recomputed apart from the slices.
    qfs_ptr_t lvl0;
    qfs_ptr_t lvl1;
    qfs_ptr_t lvl2;
    qfs_ptr_t lvl3;
    assign lvl0 = qfs_level(wr_ptr[0], rd_ptr[0]);
    assign lvl1 = qfs_level(wr_ptr[1], rd_ptr[1]);
    assign lvl2 = qfs_level(wr_ptr[2], rd_ptr[2]);
    assign lvl3 = qfs_level(wr_ptr[3], rd_ptr[3]);

    rd_match_a: assert property (
        ce && (fifo_enable == 4'hf) && (rd_ptr[0] == rd_ptr[1])
        && (rd_ptr[1] == rd_ptr[2]) && (rd_ptr[2] == rd_ptr[3])
        |=> fifo_status[`QFS_RMATCH_BIT])
        else $error("read pointer match not reported");

    wr_mismatch_a: assert property (
        ce && fifo_enable[0] && fifo_enable[1] && (wr_ptr[0] != wr_ptr[1])
        |=> !fifo_status[`QFS_WMATCH_BIT])
        else $error("write pointer match set on differing pointers");

    // A single differing pair of active pointers must clear the match bit.
    rd_mismatch_a: assert property (
        ce && fifo_enable[2] && fifo_enable[3] && (rd_ptr[2] != rd_ptr[3])
        |=> !fifo_status[`QFS_RMATCH_BIT])
        else $error("read pointer match set on differing pointers");

    wr_match_a: assert property (
        ce && (fifo_enable == 4'h6) && (wr_ptr[1] == wr_ptr[2])
        |=> fifo_status[`QFS_WMATCH_BIT])
        else $error("write pointer match not reported");

    // With no FIFO active there is nothing to compare, so both match bits stay low.
    no_active_match_a: assert property (
        ce && (fifo_enable == 4'h0)
        |=> !fifo_status[`QFS_RMATCH_BIT] && !fifo_status[`QFS_WMATCH_BIT])
        else $error("pointer match set with no FIFO enabled");

    // The aggregates must agree with the per-FIFO bits of the same word.
    any_aempty_a: assert property (
        fifo_status[`QFS_ANY_AEMPT_BIT] == |fifo_status[`QFS_AEMPTY_LSB +: 4])
        else $error("aggregate almost empty is not the OR of its bits");

    all_afull_a: assert property (
        fifo_status[`QFS_ALL_AFULL_BIT] == &fifo_status[`QFS_AFULL_LSB +: 4])
        else $error("aggregate almost full is not the AND of its bits");

    any_empty_a: assert property (
        fifo_status[`QFS_ANY_EMPTY_BIT] == |fifo_status[`QFS_EMPTY_LSB +: 4])
        else $error("aggregate empty is not the OR of its bits");

    all_full_a: assert property (
        fifo_status[`QFS_ALL_FULL_BIT] == &fifo_status[`QFS_FULL_LSB +: 4])
        else $error("aggregate full is not the AND of its bits");

    // The aggregates other than almost full are also checked from the pointers, since the checks above only
    // compare the register with itself and would pass on a wrong per-FIFO bit.
    all_full_set_a: assert property (
        ce && (fifo_enable == 4'hf) && (lvl0 == `QFS_DEPTH) && (lvl1 == `QFS_DEPTH)
        && (lvl2 == `QFS_DEPTH) && (lvl3 == `QFS_DEPTH)
        |=> fifo_status[`QFS_ALL_FULL_BIT])
        else $error("aggregate full not set with every FIFO full");

    all_full_clear_a: assert property (
        ce && (fifo_enable != 4'hf) |=> !fifo_status[`QFS_ALL_FULL_BIT])
        else $error("aggregate full set while a FIFO is disabled");

    any_empty_set_a: assert property (
        ce && fifo_enable[0] && (lvl0 == 5'h00) |=> fifo_status[`QFS_ANY_EMPTY_BIT])
        else $error("aggregate empty not set with FIFO 0 empty");

    any_aempty_set_a: assert property (
        ce && fifo_enable[2] && (lvl2 < {2'b00, empty_thresh})
        |=> fifo_status[`QFS_ANY_AEMPT_BIT])
        else $error("aggregate almost empty not set with FIFO 2 almost empty");

    // Per-FIFO bits are checked against levels recomputed here from the pointers.
    aempty_bit_a: assert property (
        ce && fifo_enable[1] && (lvl1 < {2'b00, empty_thresh})
        |=> fifo_status[`QFS_AEMPTY_LSB + 1])
        else $error("FIFO 1 almost empty not reported");

    afull_bit_a: assert property (
        ce && fifo_enable[1] && (lvl1 > {2'b00, full_thresh})
        |=> fifo_status[`QFS_AFULL_LSB + 1])
        else $error("FIFO 1 almost full not reported");

    empty_bit_a: assert property (
        ce && fifo_enable[0] && (rd_ptr[0] == wr_ptr[0])
        |=> fifo_status[`QFS_EMPTY_LSB])
        else $error("FIFO 0 empty not reported");

    // The set checks alone would pass on a flag stuck high, so each has a clear check too.
    empty_clear_a: assert property (
        ce && (rd_ptr[3] != wr_ptr[3]) |=> !fifo_status[`QFS_EMPTY_LSB + 3])
        else $error("FIFO 3 empty shown while it holds data");

    afull_clear_a: assert property (
        ce && !(lvl3 > {2'b00, full_thresh}) |=> !fifo_status[`QFS_AFULL_LSB + 3])
        else $error("FIFO 3 almost full shown below its threshold");

    aempty_clear_a: assert property (
        ce && !(lvl3 < {2'b00, empty_thresh}) |=> !fifo_status[`QFS_AEMPTY_LSB + 3])
        else $error("FIFO 3 almost empty shown at or above its threshold");

    flags_zero_a: assert property (
        ce && (fifo_enable == 4'h0) |=> fifo_status == `QFS_STATUS_RESET)
        else $error("status word not clear with every FIFO disabled");

    full_bit_a: assert property (
        ce && fifo_enable[0] |=> fifo_status[`QFS_FULL_LSB] == ($past(lvl0) == `QFS_DEPTH))
        else $error("FIFO 0 full bit wrong");

    // A disabled FIFO must read clear whatever its pointers hold.
    disabled_clear_a: assert property (
        ce && !fifo_enable[2]
        |=> !fifo_status[2] && !fifo_status[6] && !fifo_status[10] && !fifo_status[14])
        else $error("disabled FIFO 2 still shows a flag");

    // Reserved bits and the read port.
    reserved_zero_a: assert property (
        fifo_status[31:`QFS_USED_W] == 10'h000)
        else $error("reserved status bits not zero");

    read_back_a: assert property (
        ce && rd_en && (rd_addr == `QFS_STATUS_OFFSET) |=> rd_valid && (rd_data == $past(fifo_status)))
        else $error("status read returned a wrong word");

    // An unmapped address answers with zero so that a stray read cannot leak state.
    read_other_a: assert property (
        ce && rd_en && (rd_addr != `QFS_STATUS_OFFSET)
        |=> rd_valid && (rd_data == 32'h0000_0000))
        else $error("read of an unmapped address returned data");

    read_idle_a: assert property (
        ce && !rd_en |=> !rd_valid && $stable(rd_data))
        else $error("read port moved without a read request");

    // Clock enable low must freeze every flop, the read port included.
    freeze_a: assert property (
        !ce |=> $stable(fifo_status) && $stable(rd_data) && $stable(rd_valid))
        else $error("state moved while clock enable was low");

    all_full_c: cover property (fifo_status[`QFS_ALL_FULL_BIT]);
    all_match_c: cover property (fifo_status[`QFS_RMATCH_BIT] && fifo_status[`QFS_WMATCH_BIT]);
    disable_c: cover property (fifo_status[`QFS_EMPTY_LSB] ##1 !fifo_enable[0] ##1 !fifo_status[4]);
    read_c: cover property (rd_valid && (rd_data != 32'h0000_0000));
    unmapped_c: cover property (ce && rd_en && (rd_addr != `QFS_STATUS_OFFSET));

endmodule

// ==== dv/quad_fifo_status_aggregator_test.sv ====
// Purpose: Self-checking testbench of the quad FIFO status aggregator.
// Assumes: Inputs change 1 ns after the rising edge; status lags its inputs by one edge.
// Notes:   A model function derives every expected word from the driven inputs.
`timescale 1ns/10ps
`include "qfs_params.svh"

module quad_fifo_status_aggregator_test;
    import qfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Stimulus, observed outputs and expected values.
    logic         clock = 1'b0;
    logic         rst   = 1'b1;
    logic         ce    = 1'b1;
    qfs_mask_t    fifo_enable  = 4'h0;
    qfs_thr_t     full_thresh  = 3'h0;
    qfs_thr_t     empty_thresh = 3'h0;
    qfs_ptr_vec_t wr_ptr = '0;
    qfs_ptr_vec_t rd_ptr = '0;
    logic         rd_en   = 1'b0;
    qfs_addr_t    rd_addr = 16'h0004;
    logic [31:0]  rd_data;
    logic         rd_valid;
    logic [31:0]  fifo_status;
    logic [31:0]  exp_stat;
    logic [31:0]  exp_data;
    logic         exp_valid;
    integer       seed      = 49;
    int           error_cnt = 0;
    int           checks    = 0;
    int           cycle_cnt = 0;

    // A 50 ns period gives the 20 MHz status clock.
    always #25 clock = ~clock;

    qfs_status i_dut (
        .clock        (clock),
        .rst          (rst),
        .ce           (ce),
        .fifo_enable  (fifo_enable),
        .full_thresh  (full_thresh),
        .empty_thresh (empty_thresh),
        .wr_ptr       (wr_ptr),
        .rd_ptr       (rd_ptr),
        .rd_en        (rd_en),
        .rd_addr      (rd_addr),
        .rd_data      (rd_data),
        .rd_valid     (rd_valid),
        .fifo_status  (fifo_status)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Expected status word; a disabled FIFO sets no bit and counts as clear in the aggregates.
    function automatic logic [31:0] model_status(input qfs_mask_t en, input qfs_thr_t fth,
            input qfs_thr_t eth, input qfs_ptr_vec_t wp, input qfs_ptr_vec_t rp);
        logic [31:0] s;
        qfs_ptr_t    lvl;
        logic        wm;
        logic        rm;
        int          first;
        s = 32'h0000_0000;
        wm = (en != 4'h0);
        rm = wm;
        first = -1;
        for (int i = 0; i < 4; i++) begin
            lvl = wp[i] - rp[i];
            if (en[i]) begin
                s[i]      = (lvl == 5'h10);
                s[4 + i]  = (lvl == 5'h00);
                s[8 + i]  = (lvl > {2'b00, fth});
                s[12 + i] = (lvl < {2'b00, eth});
                if (first < 0) begin
                    first = i;
                end else begin
                    if (wp[i] != wp[first]) wm = 1'b0;
                    if (rp[i] != rp[first]) rm = 1'b0;
                end
            end
        end
        s[16] = &s[3:0];
        s[17] = |s[7:4];
        s[18] = &s[11:8];
        s[19] = |s[15:12];
        s[20] = wm;
        s[21] = rm;
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, stimulus and reset helpers.
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s at %0t: got %h expected %h", what, $time, got, exp);
        end
    endtask

    // Kind 0 is random, 1 all full, 2 full with enables toggling, 3 all empty.
    // Sharing one base pointer often makes the pointer-match bits reachable.
    task automatic drive(input int kind);
        qfs_ptr_t base;
        qfs_ptr_t lv;
        logic     share;
        base = 5'($random(seed));
        share = 1'($random(seed));
        ce = (($random(seed) & 7) != 0);
        fifo_enable = (kind == 1 || kind == 3) ? 4'hF : 4'($random(seed));
        full_thresh = 3'($random(seed));
        empty_thresh = 3'($random(seed));
        rd_en = 1'($random(seed));
        rd_addr = (($random(seed) & 3) == 0) ? 16'($random(seed)) : `QFS_STATUS_OFFSET;
        for (int i = 0; i < 4; i++) begin
            rd_ptr[i] = share ? base : 5'($random(seed));
            lv = (kind == 1 || kind == 2) ? 5'h10 : (kind == 3) ? 5'h00
                : 5'(($random(seed) & 32'h7FFF_FFFF) % 17);
            wr_ptr[i] = rd_ptr[i] + lv;
        end
    endtask

    // One edge: advance the model, compare after the edge, then drive anew.
    task automatic step(input int kind);
        @(posedge clock);
        if (ce === 1'b1) begin
            exp_valid = rd_en;
            if (rd_en) exp_data = (rd_addr == `QFS_STATUS_OFFSET) ? exp_stat : 32'h0000_0000;
            exp_stat = model_status(fifo_enable, full_thresh, empty_thresh, wr_ptr, rd_ptr);
        end
        #1;
        check("status", fifo_status, exp_stat);
        check("rd_valid", {31'h0000_0000, rd_valid}, {31'h0000_0000, exp_valid});
        check("rd_data", rd_data, exp_data);
        drive(kind);
    endtask

    // Reset is held six cycles; every output must read zero after the sixth edge, before release.
    task automatic do_reset();
        rst = 1'b1;
        repeat (6) @(posedge clock);
        #1;
        check("reset status", fifo_status, 32'h0000_0000);
        check("reset data", rd_data, 32'h0000_0000);
        check("reset valid", {31'h0000_0000, rd_valid}, 32'h0000_0000);
        exp_stat = 32'h0000_0000;
        exp_data = 32'h0000_0000;
        exp_valid = 1'b0;
        rst = 1'b0;
    endtask

    task automatic run(input string name, input int kind, input int n);
        repeat (n) step(kind);
        $display("Test %s done: checks %0d mismatches %0d", name, checks, error_cnt);
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // The run needs under a thousand cycles, so twice that means a hang.
    always @(posedge clock) begin
        cycle_cnt++;
        if (cycle_cnt >= 2000) begin
            error_cnt++;
            $display("Timeout after %0d cycles", cycle_cnt);
            tally_and_finish();
        end
    end

    // Main sequence, with a second reset in mid-run.
    initial begin
        do_reset();
        run("random", 0, 400);
        run("all full", 1, 20);
        run("all empty", 3, 20);
        run("enable toggling", 2, 200);
        do_reset();
        run("after reset", 0, 200);
        tally_and_finish();
    end

endmodule
